//--- rtl/ldc_pkg.sv
// Package for the laser driver control core: register map, field layout,
// reset values and the transmit control carrier.
// Assumes a 32-bit APB with byte addresses; registers sit on aligned words.
package ldc_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TX_CTRL  = 8'h00; // Transmit control
  localparam logic [7:0] OFS_EQ       = 8'h04; // Equalizer boost
  localparam logic [7:0] OFS_DEEMPH   = 8'h08; // Deemphasis setting
  localparam logic [7:0] OFS_DC_CODE  = 8'h0c; // DC code, upper 8 bits
  localparam logic [7:0] OFS_DC_LIM   = 8'h10; // DC code limit
  localparam logic [7:0] OFS_DC_STEP  = 8'h14; // DC step, bit 7 is code LSB
  localparam logic [7:0] OFS_MOD_CODE = 8'h18; // Modulation code, upper 8
  localparam logic [7:0] OFS_MOD_LIM  = 8'h1c; // Modulation code limit
  localparam logic [7:0] OFS_MOD_STEP = 8'h20; // Modulation step
  localparam logic [7:0] OFS_FMASK    = 8'h24; // Hard fault mask
  localparam logic [7:0] OFS_HSTAT    = 8'h28; // Hard fault status
  localparam logic [7:0] OFS_WSTAT    = 8'h2c; // Warning status
  localparam logic [7:0] OFS_MODE     = 8'h30; // Mode control
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SETUP_KEY    = 8'h12; // Unlocks the next access
  localparam int         SIGNAL_BIT   = 5;     // Signal present in status
  localparam int         LSB_BIT      = 7;     // Code LSB in step register
  localparam logic [7:0] RST_CODE     = 8'h04; // Small default codes
  localparam logic [7:0] RST_LIM      = 8'hff;
  localparam logic [1:0] RST_EQ       = 2'h0;
  localparam logic [6:0] RST_DEEMPH   = 7'h00;
  localparam logic [4:0] RST_FMASK    = 5'h00; // All hard faults active
  typedef struct packed {
    logic [2:0] rsv_hi;   // Reads zero
    logic [1:0] de_range; // Deemphasis range
    logic       rsv_lo;   // Reads zero
    logic       pol;      // Output polarity select
    logic       en;       // Transmit enable
  } tx_ctrl_t;
endpackage : ldc_pkg

//--- rtl/laser_driver_control_core.sv
// Laser driver control core: APB register bank, clamped code stepping,
// fault latching and output gating.
// Assumes all inputs synchronous to pclk; fault detectors are levels.
//
// Functional notes
// - Two-bit setting selects equalizer boost
// - Polarity bit may invert output pair
// - Status bit 5 shows input signal present
// - DC code nine bits, LSB from step
// - Modulation code nine bits, LSB from step
// - Five-bit signed step adds to code
// - DC overflow clamps to limit, warns
// - Modulation overflow clamps to limit, warns
// - Deemphasis from control bits and setting
// - Reset leaves transmitter off, codes small
// - Reset restores every register default
// - Level select gives upper address bits
// - Unmasked hard fault raises output and status
// - Maskable hard faults disable the currents
// - Soft faults only warn, never disable
// - Disable, enable and faults gate currents
// - High disable input stops both currents
// - Fault stays latched until disable toggles
// - Disable toggle clears both status registers
// - Normal mode writes only step and mode registers
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module laser_driver_control_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        disable_in,           // High or open: off
  input  wire logic [1:0]  address_level_select, // Digitised 4-level pin
  input  wire logic        signal_present,       // AC activity detector
  input  wire logic [4:0]  hard_fault_det,       // Hard fault detectors
  input  wire logic [3:0]  soft_fault_det,       // Soft fault detectors
  output logic [1:0]       eq_boost_setting,
  output logic             output_polarity_select,
  output logic [1:0]       deemph_range,
  output logic [6:0]       deemphasis_setting,
  output logic [8:0]       dc_current_code,
  output logic [8:0]       mod_current_code,
  output logic             currents_on,
  output logic             fault_out,
  output logic [1:0]       addr_hi
);
  // ----------------------------------------------------------------
  // Step arithmetic
  // ----------------------------------------------------------------
  // Returns {overflow, code}; floors at zero instead of wrapping
  function automatic logic [8:0] step_add(input logic [7:0] code,
                                          input logic [4:0] step,
                                          input logic [7:0] lim);
    logic signed [9:0] sum;
    sum = $signed({2'b00, code}) + $signed({{5{step[4]}}, step});
    if (sum < 0)
      step_add = 9'h000;
    else if (sum > $signed({2'b00, lim}))
      step_add = {1'b1, lim};
    else
      step_add = {1'b0, sum[7:0]};
  endfunction : step_add

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ldc_pkg::tx_ctrl_t ctrl_r, ctrl_nxt;          // Transmit control
  logic [1:0]  eq_r, eq_nxt;                     // Boost code
  logic [6:0]  de_r, de_nxt;                     // Deemphasis fraction
  logic [8:0]  dc_r, dc_nxt;                     // Full DC code
  logic [8:0]  mod_r, mod_nxt;                   // Full modulation code
  logic [7:0]  dc_lim_r, dc_lim_nxt;
  logic [7:0]  mod_lim_r, mod_lim_nxt;
  logic [4:0]  dc_stp_r, dc_stp_nxt;             // Last step written
  logic [4:0]  mod_stp_r, mod_stp_nxt;
  logic [4:0]  mask_r, mask_nxt;                 // Hard fault mask
  logic [4:0]  hst_r, hst_nxt;                   // Latched hard faults
  logic [5:0]  wst_r, wst_nxt;                   // Warnings
  logic        unlock_r, unlock_nxt;             // Setup mode armed
  logic        sig_r, sig_nxt;
  logic        dis_d_r, dis_d_nxt;               // Disable, one cycle old
  logic        on_r, on_nxt;
  logic        flt_r, flt_nxt;
  logic [1:0]  adr_r, adr_nxt;
  logic        adr_ok_r, adr_ok_nxt;             // Strap captured
  logic        rdy_r, rdy_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic        err_r, err_nxt;
  logic        acc, wr, hit, dc_ovf, mod_ovf, dis_clr;
  logic [8:0]  dc_sum, mod_sum;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // One wait state so read data can leave a flop; writes land on the
  // edge that also samples pready high.
  always_comb
  begin
    acc = psel && penable && rdy_r;
    wr  = acc && pwrite;
    dc_sum  = step_add(dc_r[8:1], pwdata[4:0], dc_lim_r);
    mod_sum = step_add(mod_r[8:1], pwdata[4:0], mod_lim_r);
    dc_ovf  = wr && (paddr == ldc_pkg::OFS_DC_STEP) && dc_sum[8];
    mod_ovf = wr && (paddr == ldc_pkg::OFS_MOD_STEP) && mod_sum[8];
    dis_clr = dis_d_r && !disable_in;            // Falling edge ends toggle
    ctrl_nxt = ctrl_r;
    eq_nxt = eq_r;
    de_nxt = de_r;
    dc_nxt = dc_r;
    mod_nxt = mod_r;
    dc_lim_nxt = dc_lim_r;
    mod_lim_nxt = mod_lim_r;
    dc_stp_nxt = dc_stp_r;
    mod_stp_nxt = mod_stp_r;
    mask_nxt = mask_r;
    unlock_nxt = acc ? 1'b0 : unlock_r;          // Setup lasts one access
    rdy_nxt = psel && penable && !rdy_r;
    rd_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    hit = 1'b1;
    // Read mux, all registers readable
    unique case (paddr)
      ldc_pkg::OFS_TX_CTRL:  rd_nxt[7:0] = ctrl_r;
      ldc_pkg::OFS_EQ:       rd_nxt[1:0] = eq_r;
      ldc_pkg::OFS_DEEMPH:   rd_nxt[6:0] = de_r;
      ldc_pkg::OFS_DC_CODE:  rd_nxt[7:0] = dc_r[8:1];
      ldc_pkg::OFS_DC_LIM:   rd_nxt[7:0] = dc_lim_r;
      ldc_pkg::OFS_DC_STEP:  rd_nxt[7:0] = {dc_r[0], 2'b00, dc_stp_r};
      ldc_pkg::OFS_MOD_CODE: rd_nxt[7:0] = mod_r[8:1];
      ldc_pkg::OFS_MOD_LIM:  rd_nxt[7:0] = mod_lim_r;
      ldc_pkg::OFS_MOD_STEP: rd_nxt[7:0] = {mod_r[0], 2'b00, mod_stp_r};
      ldc_pkg::OFS_FMASK:    rd_nxt[4:0] = mask_r;
      ldc_pkg::OFS_HSTAT:    rd_nxt[5:0] = {sig_r, hst_r};
      ldc_pkg::OFS_WSTAT:    rd_nxt[5:0] = wst_r;
      ldc_pkg::OFS_MODE:     rd_nxt[0]   = unlock_r;
      default:               hit = 1'b0;
    endcase
    if (rdy_nxt)
      err_nxt = !hit;                            // Unmapped: slave error
    else
      rd_nxt = 32'h0000_0000;
    if (wr)
    begin
      // Step registers are always writable
      if (paddr == ldc_pkg::OFS_DC_STEP)
      begin
        dc_nxt = {dc_sum[7:0], pwdata[ldc_pkg::LSB_BIT]};
        dc_stp_nxt = pwdata[4:0];
      end
      if (paddr == ldc_pkg::OFS_MOD_STEP)
      begin
        mod_nxt = {mod_sum[7:0], pwdata[ldc_pkg::LSB_BIT]};
        mod_stp_nxt = pwdata[4:0];
      end
      if (paddr == ldc_pkg::OFS_MODE)
        unlock_nxt = (pwdata[7:0] == ldc_pkg::SETUP_KEY);
      // Other settings only in setup mode; status never writable
      if (unlock_r)
      begin
        unique case (paddr)
          ldc_pkg::OFS_TX_CTRL:
            ctrl_nxt = {3'b000, pwdata[4:3], 1'b0, pwdata[1:0]};
          ldc_pkg::OFS_EQ:       eq_nxt = pwdata[1:0];
          ldc_pkg::OFS_DEEMPH:   de_nxt = pwdata[6:0];
          ldc_pkg::OFS_DC_CODE:  dc_nxt[8:1] = pwdata[7:0];
          ldc_pkg::OFS_DC_LIM:   dc_lim_nxt = pwdata[7:0];
          ldc_pkg::OFS_MOD_CODE: mod_nxt[8:1] = pwdata[7:0];
          ldc_pkg::OFS_MOD_LIM:  mod_lim_nxt = pwdata[7:0];
          ldc_pkg::OFS_FMASK:    mask_nxt = pwdata[4:0];
          default:               ;
        endcase
      end
    end
    // Faults: new events win over the toggle clear
    hst_nxt = (dis_clr ? 5'h00 : hst_r) | (hard_fault_det & ~mask_r);
    wst_nxt = (dis_clr ? 6'h00 : wst_r)
              | {soft_fault_det, mod_ovf, dc_ovf};
    sig_nxt = signal_present;
    dis_d_nxt = disable_in;
    flt_nxt = |hst_nxt;
    on_nxt = ctrl_nxt.en && !disable_in && !flt_nxt;
    // Strap taken once, on the first edge after reset release
    adr_ok_nxt = 1'b1;
    adr_nxt = adr_ok_r ? adr_r : address_level_select;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Every register returns to its default on reset; laser stays off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r    <= '0;
      eq_r      <= ldc_pkg::RST_EQ;
      de_r      <= ldc_pkg::RST_DEEMPH;
      dc_r      <= {ldc_pkg::RST_CODE, 1'b0};
      mod_r     <= {ldc_pkg::RST_CODE, 1'b0};
      dc_lim_r  <= ldc_pkg::RST_LIM;
      mod_lim_r <= ldc_pkg::RST_LIM;
      dc_stp_r  <= 5'h00;
      mod_stp_r <= 5'h00;
      mask_r    <= ldc_pkg::RST_FMASK;
      hst_r     <= 5'h00;
      wst_r     <= 6'h00;
      unlock_r  <= 1'b0;
      sig_r     <= 1'b0;
      dis_d_r   <= 1'b1;                         // Treat as disabled
      on_r      <= 1'b0;
      flt_r     <= 1'b0;
      adr_r     <= 2'h0;
      adr_ok_r  <= 1'b0;
      rdy_r     <= 1'b0;
      rd_r      <= 32'h0000_0000;
      err_r     <= 1'b0;
    end
    else
    begin
      ctrl_r    <= ctrl_nxt;
      eq_r      <= eq_nxt;
      de_r      <= de_nxt;
      dc_r      <= dc_nxt;
      mod_r     <= mod_nxt;
      dc_lim_r  <= dc_lim_nxt;
      mod_lim_r <= mod_lim_nxt;
      dc_stp_r  <= dc_stp_nxt;
      mod_stp_r <= mod_stp_nxt;
      mask_r    <= mask_nxt;
      hst_r     <= hst_nxt;
      wst_r     <= wst_nxt;
      unlock_r  <= unlock_nxt;
      sig_r     <= sig_nxt;
      dis_d_r   <= dis_d_nxt;
      on_r      <= on_nxt;
      flt_r     <= flt_nxt;
      adr_r     <= adr_nxt;
      adr_ok_r  <= adr_ok_nxt;
      rdy_r     <= rdy_nxt;
      rd_r      <= rd_nxt;
      err_r     <= err_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pready                 = rdy_r;
  assign prdata                 = rd_r;
  assign pslverr                = err_r;
  assign eq_boost_setting       = eq_r;
  assign output_polarity_select = ctrl_r.pol;
  assign deemph_range           = ctrl_r.de_range;
  assign deemphasis_setting     = de_r;
  assign dc_current_code        = dc_r;
  assign mod_current_code       = mod_r;
  assign currents_on            = on_r;
  assign fault_out              = flt_r;
  assign addr_hi                = adr_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_dc_clamp;
    @(posedge pclk) disable iff (!presetn)
      dc_ovf |=> (dc_r[8:1] == $past(dc_lim_r)) && wst_r[0];
  endproperty
  a_dc_clamp: assert property (p_dc_clamp) else $error("dc clamp missed");
  property p_mod_clamp;
    @(posedge pclk) disable iff (!presetn)
      mod_ovf |=> (mod_r[8:1] == $past(mod_lim_r)) && wst_r[1];
  endproperty
  a_mod_clamp: assert property (p_mod_clamp) else $error("mod clamp missed");
  property p_dc_lsb;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == ldc_pkg::OFS_DC_STEP) |=> dc_r[0] == $past(pwdata[7]);
  endproperty
  a_dc_lsb: assert property (p_dc_lsb) else $error("dc lsb wrong");
  property p_mod_lsb;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == ldc_pkg::OFS_MOD_STEP) |=> mod_r[0] == $past(pwdata[7]);
  endproperty
  a_mod_lsb: assert property (p_mod_lsb) else $error("mod lsb wrong");
  property p_floor;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == ldc_pkg::OFS_DC_STEP && pwdata[4] && dc_r[8:1] < 8'h10)
      |=> dc_r[8:1] <= $past(dc_r[8:1]);
  endproperty
  a_floor: assert property (p_floor) else $error("dc code wrapped");
  property p_hard_off;
    @(posedge pclk) disable iff (!presetn)
      |(hard_fault_det & ~mask_r) |=> fault_out && !currents_on;
  endproperty
  a_hard_off: assert property (p_hard_off) else $error("hard fault ignored");
  property p_latch;
    @(posedge pclk) disable iff (!presetn)
      (fault_out && !dis_clr) |=> fault_out;
  endproperty
  a_latch: assert property (p_latch) else $error("fault dropped early");
  property p_disable;
    @(posedge pclk) disable iff (!presetn)
      disable_in |=> !currents_on;
  endproperty
  a_disable: assert property (p_disable) else $error("on while disabled");
  property p_locked;
    @(posedge pclk) disable iff (!presetn)
      (wr && !unlock_r && paddr == ldc_pkg::OFS_TX_CTRL) |=> $stable(ctrl_r);
  endproperty
  a_locked: assert property (p_locked) else $error("locked write landed");
  property p_soft;
    @(posedge pclk) disable iff (!presetn)
      (soft_fault_det[0] && !flt_r && hard_fault_det == 5'h00) |=> !fault_out;
  endproperty
  a_soft: assert property (p_soft) else $error("soft fault tripped");
endmodule : laser_driver_control_core
`default_nettype wire

//--- tb/apb_ctrl_model.sv
// Controller model: APB master standing in for the external controller.
// Assumes the bench calls xfer one transfer at a time; pclk is free running.
`timescale 1ns/1ps
`default_nettype none
module apb_ctrl_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  // ----------------------------------------------------------------
  // Idle bus at time zero
  // ----------------------------------------------------------------
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // ----------------------------------------------------------------
  // One transfer; request held until pready is seen high at an edge
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Read before this edge's updates land, so the sampled answer is seen
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : apb_ctrl_model
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the laser driver control core.
// Assumes the controller model drives APB; bench drives the pin inputs.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        disable_in, signal_present, e, output_polarity_select;
  logic        currents_on, fault_out;
  logic [1:0]  address_level_select, eq_boost_setting, deemph_range, addr_hi;
  logic [4:0]  hard_fault_det;
  logic [3:0]  soft_fault_det;
  logic [6:0]  deemphasis_setting;
  logic [8:0]  dc_current_code, mod_current_code;
  int          bad_count, check_count, cycles;

  // ----------------------------------------------------------------
  // Design, controller model and clock
  // ----------------------------------------------------------------
  laser_driver_control_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .disable_in(disable_in),
    .address_level_select(address_level_select), .signal_present(signal_present),
    .hard_fault_det(hard_fault_det), .soft_fault_det(soft_fault_det),
    .eq_boost_setting(eq_boost_setting), .output_polarity_select(output_polarity_select),
    .deemph_range(deemph_range), .deemphasis_setting(deemphasis_setting),
    .dc_current_code(dc_current_code), .mod_current_code(mod_current_code),
    .currents_on(currents_on), .fault_out(fault_out), .addr_hi(addr_hi));
  apb_ctrl_model ctl (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("TB: checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ctl.xfer(1'b1, a, d, q, e);
  endtask : wr

  // Setup key arms exactly one unrestricted access
  task automatic wr_setup(input logic [7:0] a, input logic [31:0] d);
    wr(ldc_pkg::OFS_MODE, 32'h12);
    wr(a, d);
  endtask : wr_setup

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] d, input logic er);
    ctl.xfer(1'b0, a, 32'h0, q, e);
    chk(q, d);
    chk({31'h0, e}, {31'h0, er});
  endtask : rd_chk

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : do_reset

  // Step write, then code compared as a nine-bit value
  task automatic step_chk(input int s, input logic [7:0] a, input logic [31:0] d,
                          input logic [8:0] x);
    wr(a, d);
    settle();
    chk({23'h0, (s == 1) ? mod_current_code : dc_current_code}, {23'h0, x});
  endtask : step_chk

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 4; i++)
    begin
      address_level_select <= 2'(i);
      do_reset();
      chk({30'h0, addr_hi}, 32'(i));
    end
    chk({23'h0, dc_current_code}, 32'h8);
    chk({23'h0, mod_current_code}, 32'h8);
    chk({30'h0, currents_on, fault_out}, 32'h0);
    rd_chk(ldc_pkg::OFS_TX_CTRL, 32'h0, 1'b0);
    rd_chk(ldc_pkg::OFS_DC_LIM, 32'hff, 1'b0);
    rd_chk(ldc_pkg::OFS_FMASK, 32'h0, 1'b0);
    $display("TB: reset test done");
  endtask : t_reset

  task automatic t_access;
    logic [1:0] codes [3] = '{2'h0, 2'h1, 2'h3};
    wr(ldc_pkg::OFS_EQ, 32'h3);
    rd_chk(ldc_pkg::OFS_EQ, 32'h0, 1'b0);
    wr(ldc_pkg::OFS_MODE, 32'h12);
    rd_chk(ldc_pkg::OFS_EQ, 32'h0, 1'b0);
    wr(ldc_pkg::OFS_EQ, 32'h3);
    rd_chk(ldc_pkg::OFS_EQ, 32'h0, 1'b0);
    foreach (codes[k])
    begin
      wr_setup(ldc_pkg::OFS_EQ, {30'h0, codes[k]});
      settle();
      chk({30'h0, eq_boost_setting}, {30'h0, codes[k]});
    end
    wr_setup(ldc_pkg::OFS_TX_CTRL, 32'h13);
    wr_setup(ldc_pkg::OFS_DEEMPH, 32'h55);
    settle();
    chk({31'h0, output_polarity_select}, 32'h1);
    chk({30'h0, deemph_range}, 32'h2);
    chk({25'h0, deemphasis_setting}, 32'h55);
    // Locked write to transmit control must not land
    wr(ldc_pkg::OFS_TX_CTRL, 32'h00);
    rd_chk(ldc_pkg::OFS_TX_CTRL, 32'h13, 1'b0);
    rd_chk(8'h34, 32'h0, 1'b1);
    $display("TB: access test done");
  endtask : t_access

  task automatic t_step;
    logic [7:0] st, lm;
    for (int s = 0; s < 2; s++)
    begin
      st = (s == 1) ? ldc_pkg::OFS_MOD_STEP : ldc_pkg::OFS_DC_STEP;
      lm = (s == 1) ? ldc_pkg::OFS_MOD_LIM : ldc_pkg::OFS_DC_LIM;
      step_chk(s, st, 32'h8f, 9'h027);
      step_chk(s, st, 32'h10, 9'h006);
      step_chk(s, st, 32'h10, 9'h000);
      wr_setup(lm, 32'h10);
      step_chk(s, st, 32'h0f, 9'h01e);
      step_chk(s, st, 32'h0f, 9'h020);
      rd_chk(ldc_pkg::OFS_WSTAT, (s == 1) ? 32'h3 : 32'h1, 1'b0);
    end
    // Direct code writes in setup mode; status stays unwritable
    wr_setup(ldc_pkg::OFS_DC_CODE, 32'h0c);
    wr_setup(ldc_pkg::OFS_MOD_CODE, 32'h0d);
    wr_setup(ldc_pkg::OFS_WSTAT, 32'h00);
    settle();
    chk({23'h0, dc_current_code}, 32'h18);
    chk({23'h0, mod_current_code}, 32'h1a);
    rd_chk(ldc_pkg::OFS_WSTAT, 32'h3, 1'b0);
    $display("TB: step test done");
  endtask : t_step

  task automatic t_fault;
    disable_in <= 1'b0;
    signal_present <= 1'b1;
    settle();
    chk({31'h0, currents_on}, 32'h1);
    rd_chk(ldc_pkg::OFS_HSTAT, 32'h20, 1'b0);
    hard_fault_det <= 5'h04;
    settle();
    chk({30'h0, fault_out, currents_on}, 32'h2);
    rd_chk(ldc_pkg::OFS_HSTAT, 32'h24, 1'b0);
    hard_fault_det <= 5'h00;
    settle();
    chk({30'h0, fault_out, currents_on}, 32'h2);
    disable_in <= 1'b1;
    settle();
    chk({31'h0, currents_on}, 32'h0);
    disable_in <= 1'b0;
    settle();
    chk({30'h0, fault_out, currents_on}, 32'h1);
    rd_chk(ldc_pkg::OFS_HSTAT, 32'h20, 1'b0);
    rd_chk(ldc_pkg::OFS_WSTAT, 32'h0, 1'b0);
    soft_fault_det <= 4'h5;
    settle();
    rd_chk(ldc_pkg::OFS_WSTAT, 32'h14, 1'b0);
    chk({31'h0, currents_on}, 32'h1);
    wr_setup(ldc_pkg::OFS_FMASK, 32'h04);
    hard_fault_det <= 5'h04;
    settle();
    chk({30'h0, fault_out, currents_on}, 32'h1);
    rd_chk(ldc_pkg::OFS_HSTAT, 32'h20, 1'b0);
    $display("TB: fault test done");
  endtask : t_fault

  // Mid-run reset must undo the DC code, boost and mask settings made above
  task automatic t_rerun;
    hard_fault_det <= 5'h00;
    do_reset();
    chk({23'h0, dc_current_code}, 32'h8);
    chk({30'h0, eq_boost_setting}, 32'h0);
    chk({30'h0, currents_on, fault_out}, 32'h0);
    rd_chk(ldc_pkg::OFS_FMASK, 32'h0, 1'b0);
    $display("TB: rerun test done");
  endtask : t_rerun

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    disable_in = 1'b1;
    signal_present = 1'b0;
    hard_fault_det = 5'h00;
    soft_fault_det = 4'h0;
    address_level_select = 2'h0;
    bad_count = 0;
    check_count = 0;
    t_reset();
    t_access();
    t_step();
    t_fault();
    t_rerun();
    final_report();
  end

  // Whole run needs well under a thousand cycles; this ceiling is generous
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      final_report();
    end
  end
endmodule : testbench
`default_nettype wire
